/* File: core/lpm_pkg.sv */
// Shared constants of the LED driver monitor and protection block.
package lpm_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned AXI_AW = 8;
  // Register indices; byte address is four times the index.
  localparam logic [3:0] IDX_CODE_A = 4'h0;
  localparam logic [3:0] IDX_CODE_B = 4'h1;
  localparam logic [3:0] IDX_CODE_C = 4'h2;
  localparam logic [3:0] IDX_TLIM = 4'h3;
  localparam logic [3:0] IDX_MEAS = 4'h4;
  localparam logic [3:0] IDX_CTRL = 4'h5;
  localparam logic [3:0] IDX_STATUS = 4'h6;
  localparam logic [3:0] IDX_MASK = 4'h7;
  localparam logic [3:0] IDX_STATE = 4'h8;
  localparam logic [3:0] IDX_UVTH = 4'h9;
  // Field positions.
  localparam int unsigned TLIM_EN_LSB = 4;
  localparam int unsigned MEAS_GAIN_LSB = 4;
  localparam int unsigned MEAS_CAL_BIT = 6;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned ST_WARN = 0;
  localparam int unsigned ST_TSD = 1;
  localparam int unsigned ST_BATLOW = 2;
  localparam int unsigned ST_UNDERVOLTAGE_LOCKOUT = 3;
  localparam int unsigned NFLAGS = 4;
  // Reset values.
  localparam logic [9:0] RST_CODE = 10'h000;
  localparam logic [6:0] RST_TLIM = 7'h00;
  localparam logic [6:0] RST_MEAS = 7'h08;
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [7:0] RST_UVTH = 8'h00;
  // Encodings.
  localparam logic [3:0] MEAS_NONE = 4'h8;
  localparam logic [3:0] MEAS_LAST = 4'h9;
  localparam logic [7:0] UVTH_MAX = 8'h1f;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Timing.
  localparam int unsigned PARK_US = 100;
  localparam int unsigned PARK_CYC = PARK_US * CLK_MHZ;
  localparam int unsigned DISCH_US = 10;
  localparam int unsigned DISCH_CYC = DISCH_US * CLK_MHZ;
  localparam int unsigned SEQ_CW = 16;
endpackage

/* File: core/lpm_strobe.sv */
// Colour strobe decoder: switch closure and current code selection.
`timescale 1ns/100ps
module lpm_strobe
  import lpm_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic [1:0] colour_select, // 0 none, 1..3 switch a..c.
  input wire logic [29:0] switch_current_code, // Codes c, b, a.
  output logic [2:0] led_switch, // Closed switches c, b, a.
  output logic [9:0] current_code // Code of the closed switch.
);
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sw
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          led_switch[i] <= 1'b0;
        end else begin
          led_switch[i] <= colour_select == 2'(i + 1);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      current_code <= RST_CODE;
    end else if (colour_select == 2'd0) begin
      current_code <= RST_CODE;
    end else begin
      current_code <= switch_current_code[10*(colour_select-1) +: 10];
    end
  end

  strobe_sel_a: assert property (@(posedge clock) disable iff (rst)
    colour_select == 2'd2 |=> led_switch == 3'b010)
    else $error("switch b not closed for colour two");
endmodule // lpm_strobe

/* File: core/lpm_top.sv */
// LED driver control, measurement setup and protection with AXI4-Lite.
`timescale 1ns/100ps
module lpm_top
  import lpm_pkg::*;
#(
  parameter int unsigned PARK_CYCLES = PARK_CYC
)(
  input wire logic clock, // 100 MHz system clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [AXI_AW-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [AXI_AW-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [1:0] colour_select, // Colour strobe code.
  input wire logic power_on_request, // Power-on request pin.
  input wire logic temp_warn, // Junction above warning level.
  input wire logic temp_shutdown, // Junction above shutdown level.
  input wire logic battery_low, // Battery below low-battery level.
  input wire logic battery_below_uv, // Battery below programmed level.
  input wire logic battery_released, // Input above release level.
  output logic [2:0] led_switch, // Closed switches c, b, a.
  output logic [9:0] led_current_code, // Code driving regulation.
  output logic [3:0] transient_limit_level, // Transient limit level.
  output logic [2:0] transient_limit_enable, // Per-switch enables.
  output logic [9:0] meas_route, // One-hot measurement route.
  output logic [1:0] meas_gain, // Amplifier gain code.
  output logic meas_cal_disable, // Calibration disable.
  output logic [4:0] uv_threshold_code, // Undervoltage level code.
  output logic rails_enable, // Mirror and LED rails on.
  output logic standby, // Device in standby.
  output logic mirror_park, // Mirror park phase.
  output logic mirror_discharge, // Fast discharge of mirror supplies.
  output logic irq_out_n, // Interrupt pin drive level.
  output logic irq_oe // Interrupt pin output enable.
);
  logic [9:0] switch_current_code [3];
  logic [6:0] transient_limit_reg;
  logic [6:0] meas_cfg;
  logic mirror_supply_enable;
  logic [NFLAGS-1:0] status;
  logic [NFLAGS-1:0] mask;
  logic [7:0] undervoltage_threshold;
  logic lockout;
  logic por_prev;
  logic aw_held;
  logic w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [3:0] wr_idx;
  logic [31:0] wr_word;
  logic uv_event;
  logic por_rise;
  logic [NFLAGS-1:0] flag_set;
  logic seq_park;
  logic seq_disch;

  function automatic logic hit(input logic [AXI_AW-1:0] a);
    return a[AXI_AW-1:2] <= (AXI_AW-2)'(MEAS_LAST) && a[1:0] == 2'b00;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rd(input logic [3:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (idx)
      IDX_CODE_A: v[9:0] = switch_current_code[0];
      IDX_CODE_B: v[9:0] = switch_current_code[1];
      IDX_CODE_C: v[9:0] = switch_current_code[2];
      IDX_TLIM: v[6:0] = transient_limit_reg;
      IDX_MEAS: v[6:0] = meas_cfg;
      IDX_CTRL: v[CTRL_EN_BIT] = mirror_supply_enable;
      IDX_STATUS: v[NFLAGS-1:0] = status;
      IDX_MASK: v[NFLAGS-1:0] = mask;
      IDX_STATE: v[4:0] = {seq_disch, seq_park, lockout, standby,
                           rails_enable};
      IDX_UVTH: v[7:0] = undervoltage_threshold;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx = aw_addr[5:2];
  // A process, not an assign, so a register change re-merges the word.
  always_comb begin
    wr_word = merge(rd(wr_idx), w_data, w_strb);
  end
  assign uv_event = battery_below_uv && !lockout;
  assign por_rise = power_on_request && !por_prev;
  assign flag_set = {uv_event, battery_low, temp_shutdown, temp_warn};

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data are taken in either order.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel; data is one cycle after the address is taken.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= hit(s_axi_araddr) ? rd(s_axi_araddr[5:2]) : '0;
      s_axi_rresp <= hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 3; k++) begin
        switch_current_code[k] <= RST_CODE;
      end
      transient_limit_reg <= RST_TLIM;
      meas_cfg <= RST_MEAS;
      mask <= RST_MASK;
      undervoltage_threshold <= RST_UVTH;
    end else if (do_write && hit(aw_addr)) begin
      unique case (wr_idx)
        IDX_CODE_A: switch_current_code[0] <= wr_word[9:0];
        IDX_CODE_B: switch_current_code[1] <= wr_word[9:0];
        IDX_CODE_C: switch_current_code[2] <= wr_word[9:0];
        IDX_TLIM: transient_limit_reg <= wr_word[6:0];
        IDX_MEAS: begin
          meas_cfg <= wr_word[6:0];
          if (wr_word[3:0] > MEAS_LAST) begin
            meas_cfg[3:0] <= MEAS_NONE;
          end
        end
        IDX_MASK: mask <= wr_word[NFLAGS-1:0];
        IDX_UVTH: undervoltage_threshold <=
          wr_word[7:0] > UVTH_MAX ? UVTH_MAX : wr_word[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mirror supply enable; hardware faults override a software write.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mirror_supply_enable <= 1'b0;
    end else if (temp_shutdown || uv_event) begin
      mirror_supply_enable <= 1'b0;
    end else if (do_write && hit(aw_addr) && wr_idx == IDX_CTRL &&
                 !lockout) begin
      mirror_supply_enable <= wr_word[CTRL_EN_BIT];
    end
  end

  // Lockout after undervoltage, left only on a request toggle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lockout <= 1'b0;
      por_prev <= 1'b0;
    end else begin
      por_prev <= power_on_request;
      if (uv_event) begin
        lockout <= 1'b1;
      end else if (por_rise && battery_released && !seq_park &&
                   !seq_disch) begin
        lockout <= 1'b0;
      end
    end
  end

  lpm_uv_seq #(
    .PARK_CYCLES(PARK_CYCLES)
  ) u_seq (
    .clock(clock),
    .rst(rst),
    .start(uv_event),
    .parking(seq_park),
    .discharging(seq_disch)
  );

  // Rails stay up through the park phase so the mirrors can settle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rails_enable <= 1'b0;
      standby <= 1'b1;
      mirror_park <= 1'b0;
      mirror_discharge <= 1'b0;
    end else begin
      rails_enable <= (mirror_supply_enable && power_on_request &&
                       !temp_shutdown && !lockout) ||
                      (rails_enable && lockout && !seq_disch &&
                       !temp_shutdown);
      standby <= lockout || !mirror_supply_enable;
      mirror_park <= seq_park;
      mirror_discharge <= seq_disch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags, write one to clear; a new event wins over a clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else if (do_write && hit(aw_addr) && wr_idx == IDX_STATUS) begin
      status <= (status & ~wr_word[NFLAGS-1:0]) | flag_set;
    end else begin
      status <= status | flag_set;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_out_n <= 1'b1;
      irq_oe <= 1'b0;
    end else begin
      irq_out_n <= ~|(status & mask);
      irq_oe <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs for the analog front end and limiter.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      transient_limit_level <= RST_TLIM[3:0];
      transient_limit_enable <= RST_TLIM[6:4];
      meas_route <= '0;
      meas_gain <= RST_MEAS[5:4];
      meas_cal_disable <= 1'b0;
      uv_threshold_code <= RST_UVTH[4:0];
    end else begin
      transient_limit_level <= transient_limit_reg[3:0];
      transient_limit_enable <= transient_limit_reg[TLIM_EN_LSB +: 3];
      meas_route <= 10'(1) << meas_cfg[3:0];
      if (meas_cfg[3:0] == MEAS_NONE) begin
        meas_route <= '0;
      end
      meas_gain <= meas_cfg[MEAS_GAIN_LSB +: 2];
      meas_cal_disable <= meas_cfg[MEAS_CAL_BIT];
      uv_threshold_code <= undervoltage_threshold[4:0];
    end
  end

  lpm_strobe u_strobe (
    .clock(clock),
    .rst(rst),
    .colour_select(colour_select),
    .switch_current_code({switch_current_code[2], switch_current_code[1],
                          switch_current_code[0]}),
    .led_switch(led_switch),
    .current_code(led_current_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  tsd_rails_a: assert property (@(posedge clock) disable iff (rst)
    temp_shutdown |=> !rails_enable && status[ST_TSD])
    else $error("rails up or flag clear after thermal shutdown");
  warn_flag_a: assert property (@(posedge clock) disable iff (rst)
    temp_warn && !temp_shutdown && !uv_event && !do_write &&
    mirror_supply_enable |=> status[ST_WARN] && mirror_supply_enable)
    else $error("warning flag missing or enable dropped");
  cool_off_a: assert property (@(posedge clock) disable iff (rst)
    !mirror_supply_enable && !rails_enable |=> !rails_enable)
    else $error("rails on without the enable bit");
  batlow_flag_a: assert property (@(posedge clock) disable iff (rst)
    battery_low |=> status[ST_BATLOW])
    else $error("low battery flag not set");
  uv_event_a: assert property (@(posedge clock) disable iff (rst)
    uv_event |=> !mirror_supply_enable && lockout && status[ST_UNDERVOLTAGE_LOCKOUT]
    ##2 mirror_park)
    else $error("undervoltage response incomplete");
  uvth_range_a: assert property (@(posedge clock) disable iff (rst)
    undervoltage_threshold <= UVTH_MAX)
    else $error("undervoltage threshold beyond last step");
  uv_hold_a: assert property (@(posedge clock) disable iff (rst)
    lockout && !battery_released |=> lockout)
    else $error("lockout left before voltage release");
  meas_none_a: assert property (@(posedge clock) disable iff (rst)
    meas_cfg[3:0] == MEAS_NONE |=> meas_route == 10'h000)
    else $error("no-connect code routed an input");
  irq_pin_a: assert property (@(posedge clock) disable iff (rst)
    |(status & mask) |=> irq_oe && !irq_out_n)
    else $error("interrupt pin not pulled low");
  code_sel_a: assert property (@(posedge clock) disable iff (rst)
    colour_select == 2'd1 |=> led_current_code ==
    $past(switch_current_code[0]))
    else $error("wrong current code for switch a");
endmodule // lpm_top

/* File: core/lpm_uv_seq.sv */
// Undervoltage shutdown sequencer: mirror park delay then fast discharge.
`timescale 1ns/100ps
module lpm_uv_seq
  import lpm_pkg::*;
#(
  parameter int unsigned PARK_CYCLES = PARK_CYC
)(
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset.
  input wire logic start, // One-cycle undervoltage event.
  output logic parking, // Mirrors are being parked.
  output logic discharging // Fast discharge of mirror supplies.
);
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_PARK = 3'b010,
    SQ_DISCH = 3'b100
  } lpm_seq_e;
  lpm_seq_e state;
  logic [SEQ_CW-1:0] count;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= SQ_IDLE;
      count <= '0;
    end else begin
      unique case (state)
        SQ_IDLE: begin
          if (start) begin
            state <= SQ_PARK;
            count <= SEQ_CW'(PARK_CYCLES - 1);
          end
        end
        SQ_PARK: begin
          if (count == '0) begin
            state <= SQ_DISCH;
            count <= SEQ_CW'(DISCH_CYC - 1);
          end else begin
            count <= count - 1'b1;
          end
        end
        SQ_DISCH: begin
          if (count == '0) begin
            state <= SQ_IDLE;
          end else begin
            count <= count - 1'b1;
          end
        end
        default: state <= SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      parking <= 1'b0;
      discharging <= 1'b0;
    end else begin
      parking <= state == SQ_PARK && count != '0;
      discharging <= (state == SQ_PARK && count == '0) ||
                     (state == SQ_DISCH && count != '0);
    end
  end

  park_first_a: assert property (@(posedge clock) disable iff (rst)
    $rose(discharging) |-> $past(parking))
    else $error("discharge began without a park phase");
endmodule // lpm_uv_seq

/* File: test/led_pmic_monitor_protect_bench.sv */
// Register, strobe, measurement and protection tests of the LED monitor.
`timescale 1ns/100ps
module led_pmic_monitor_protect_bench
  import lpm_pkg::*;
;
  logic clock, rst, power_on_request, temp_warn, temp_shutdown;
  logic battery_low, battery_below_uv, battery_released;
  logic [1:0] colour_select, s_axi_bresp, s_axi_rresp, meas_gain, r, g;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
  logic [3:0] s_axi_wstrb, transient_limit_level;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, meas_cal_disable;
  logic [2:0] led_switch, transient_limit_enable;
  logic [9:0] led_current_code, meas_route;
  logic [4:0] uv_threshold_code;
  logic rails_enable, standby, mirror_park, mirror_discharge;
  logic irq_out_n, irq_oe;
  int err_total = 0, cmp_count = 0, cyc_n = 0, n;
  logic [9:0] codes [3] = '{10'h3ff, 10'h029, 10'h155};
  lpm_top #(.PARK_CYCLES(20)) i_dut (.*);
  lpm_host_model i_host (.*);
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("errors %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
      err_total++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic w(input logic [3:0] i, input logic [31:0] x);
    i_host.wr({2'h0, i, 2'h0}, x, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask
  task automatic rc(input logic [3:0] i, input logic [31:0] e);
    i_host.rd({2'h0, i, 2'h0}, d, r);
    chk(d, e);
  endtask
  task automatic tog();
    @(posedge clock);
    power_on_request <= 1'h0;
    repeat (2) @(posedge clock);
    power_on_request <= 1'h1;
    cyc(3);
  endtask
  always @(posedge clock) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    {temp_warn, temp_shutdown, battery_low, battery_below_uv} = '0;
    {power_on_request, battery_released, colour_select} = '0;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    cyc(2);
    rc(IDX_MEAS, 32'(RST_MEAS));
    rc(IDX_UVTH, 32'h0000_0000);
    rc(IDX_STATUS, 32'h0000_0000);
    for (int k = 0; k < 3; k++) w(4'(k), 32'(codes[k]));
    for (int k = 0; k < 3; k++) begin
      rc(4'(k), 32'(codes[k]));
      @(posedge clock);
      colour_select <= 2'(k + 1);
      cyc(3);
      chk(32'(led_switch), 32'(1) << k);
      chk(32'(led_current_code), 32'(codes[k]));
    end
    w(IDX_TLIM, 32'h0000_001c);
    cyc(2);
    chk(32'({transient_limit_enable, transient_limit_level}), 32'h1c);
    for (int s = 0; s < 10; s++) begin
      g = (s == 4) ? 2'h3 : (s > 4 && s < 8) ? 2'h2 : (s == 8) ? 2'h0 : 2'h1;
      v = {25'h0, s == 4, g, 4'(s)};
      w(IDX_MEAS, v);
      cyc(2);
      chk(32'(meas_route), (s == 8) ? 32'h0 : 32'(1) << s);
      chk(32'({meas_cal_disable, meas_gain}), v >> 4);
    end
    w(IDX_MEAS, 32'h0000_000f);
    rc(IDX_MEAS, 32'h0000_0008);
    w(IDX_UVTH, 32'h0000_0040);
    rc(IDX_UVTH, 32'(UVTH_MAX));
    chk(32'(uv_threshold_code), 32'h0000_001f);
    i_host.wr(8'h40, 32'h0000_0000, r);
    chk(32'(r), 32'(RESP_SLVERR));
    i_host.rd(8'h40, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    @(posedge clock);
    power_on_request <= 1'h1;
    battery_released <= 1'h1;
    w(IDX_MASK, 32'h0000_000b);
    w(IDX_CTRL, 32'h0000_0001);
    @(posedge clock);
    temp_warn <= 1'h1;
    cyc(4);
    chk(32'({irq_oe, irq_out_n}), 32'h2);
    chk(32'(rails_enable), 32'h1);
    @(posedge clock);
    temp_warn <= 1'h0;
    rc(IDX_STATUS, 32'h0000_0001);
    w(IDX_STATUS, 32'h0000_0001);
    cyc(4);
    chk(32'(irq_oe), 32'h0);
    @(posedge clock);
    battery_low <= 1'h1;
    cyc(4);
    chk(32'({irq_oe, rails_enable}), 32'h1);
    @(posedge clock);
    battery_low <= 1'h0;
    rc(IDX_STATUS, 32'h0000_0004);
    w(IDX_STATUS, 32'h0000_0004);
    @(posedge clock);
    temp_shutdown <= 1'h1;
    cyc(3);
    chk(32'(rails_enable), 32'h0);
    @(posedge clock);
    temp_shutdown <= 1'h0;
    rc(IDX_STATUS, 32'h0000_0002);
    chk(32'(rails_enable), 32'h0);
    w(IDX_STATUS, 32'h0000_0002);
    w(IDX_CTRL, 32'h0000_0001);
    cyc(3);
    chk(32'(rails_enable), 32'h1);
    @(posedge clock);
    battery_below_uv <= 1'h1;
    battery_released <= 1'h0;
    @(posedge clock);
    battery_below_uv <= 1'h0;
    cyc(4);
    chk(32'({rails_enable, mirror_park}), 32'h3);
    rc(IDX_CTRL, 32'h0000_0000);
    rc(IDX_STATUS, 32'h0000_0008);
    for (n = 0; n < 50 && mirror_discharge !== 1'h1; n++) cyc(1);
    chk(32'({mirror_park, mirror_discharge}), 32'h1);
    for (n = 0; n < 1100 && mirror_discharge !== 1'h0; n++) cyc(1);
    chk(32'({rails_enable, standby}), 32'h1);
    w(IDX_CTRL, 32'h0000_0001);
    tog();
    chk(32'(rails_enable), 32'h0);
    @(posedge clock);
    battery_released <= 1'h1;
    tog();
    w(IDX_CTRL, 32'h0000_0001);
    cyc(3);
    chk(32'(rails_enable), 32'h1);
    tally_and_finish();
  end
endmodule // led_pmic_monitor_protect_bench

/* File: test/lpm_host_model.sv */
// Host model that drives the AXI4-Lite register bus one transfer at a time.
`timescale 1ns/100ps
module lpm_host_model
  import lpm_pkg::*;
(
  input wire logic clock, // System clock.
  output logic [AXI_AW-1:0] s_axi_awaddr, // Write address.
  output logic s_axi_awvalid, // Address valid.
  input wire logic s_axi_awready, // Address ready.
  output logic [31:0] s_axi_wdata, // Write data.
  output logic [3:0] s_axi_wstrb, // Byte strobes.
  output logic s_axi_wvalid, // Data valid.
  input wire logic s_axi_wready, // Data ready.
  input wire logic [1:0] s_axi_bresp, // Write response.
  input wire logic s_axi_bvalid, // Response valid.
  output logic s_axi_bready, // Response ready.
  output logic [AXI_AW-1:0] s_axi_araddr, // Read address.
  output logic s_axi_arvalid, // Address valid.
  input wire logic s_axi_arready, // Address ready.
  input wire logic [31:0] s_axi_rdata, // Read data.
  input wire logic [1:0] s_axi_rresp, // Read response.
  input wire logic s_axi_rvalid, // Read valid.
  output logic s_axi_rready // Read ready.
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  //////////////////////////////////////////////////////////////////////
  // Handshakes are judged at the falling edge, where inputs are settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clock);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!tb);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clock);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'h0;
    end while (!tr);
    s_axi_rready <= 1'h0;
  endtask
endmodule // lpm_host_model
